// *** common/nv_cfg_pkg.sv ***
/*
 package for the nonvolatile configuration save/load control block.
 assumes a byte-wide register port and a byte-wide script/data memory port.
*/
package nv_cfg_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_PENDING = 12'hB00;
   localparam logic [11:0] ADDR_ERROR = 12'hB01;
   localparam logic [11:0] ADDR_RELOAD = 12'hB02;
   localparam logic [11:0] ADDR_SAVE = 12'hB03;
   localparam logic [11:0] ADDR_STATUS_SEL = 12'h01D;
   localparam logic [11:0] ADDR_UPDATE = 12'h232;
   localparam logic [11:0] ADDR_SCRIPT_BASE = 12'hA00;
   localparam int BIT_PENDING = 0;
   localparam int BIT_ERROR = 0;
   localparam int BIT_UNLOCK = 0;
   localparam int BIT_RELOAD = 1;
   localparam int BIT_SAVE = 0;
   localparam int BIT_STATUS_SEL = 7;
   localparam int BIT_UPDATE = 0;
   // ------------------------------------------------------------
   // script encoding
   // ------------------------------------------------------------
   localparam int BIT_OPCODE = 7;
   localparam logic [7:0] OP_COMMIT = 8'h80;
   localparam logic [7:0] OP_END = 8'hFF;
   localparam logic [7:0] SCRIPT_LAST = 8'hFF;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int IDLE_GAP_US = 10;
   localparam int IDLE_GAP_CYC = IDLE_GAP_US * CLK_MHZ;
   typedef enum logic [2:0] {
      S_IDLE, S_CMD, S_ADDR_HI, S_ADDR_LO, S_MOVE, S_DONE
   } eng_state_t;
endpackage : nv_cfg_pkg

// *** design/nv_config_save_load_control.sv ***
/*
 save/load engine between the register buffer bank and the nonvolatile store,
 its six control/status registers, and the 8-word data fifo.
 assumes a synchronous byte register port from the serial controller, a
 combinational buffer-bank read port, and a store that accepts/returns one
 byte per handshake with a check flag on loaded bytes.
*/
`timescale 1ns/10ps
`default_nettype none

module nv_data_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic flush,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
   } fifo_t;
   fifo_t st_q, st_d;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : bump

   always_comb begin
      logic push;
      logic pop;
      push = 1'b0;
      pop = 1'b0;
      st_d = st_q;
      inReady = (st_q.count != (AW + 1)'(DEPTH));
      outValid = (st_q.count != '0);
      outData = st_q.mem[st_q.rdPtr];
      push = inValid && inReady;
      pop = outValid && outReady;
      if (push) begin
         st_d.mem[st_q.wrPtr] = inData;
         st_d.wrPtr = bump(st_q.wrPtr);
      end
      if (pop) begin
         st_d.rdPtr = bump(st_q.rdPtr);
      end
      if (push && !pop) begin
         st_d.count = st_q.count + 1'b1;
      end else if (pop && !push) begin
         st_d.count = st_q.count - 1'b1;
      end
      if (flush) begin
         st_d.wrPtr = '0;
         st_d.rdPtr = '0;
         st_d.count = '0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
      end else if (clkEn) begin
         st_q <= st_d;
      end
   end
endmodule : nv_data_fifo

// Contract
// - pending flag reads one during transfer
// - status pin mirrors pending when selected
// - error flag shows bad data loaded from store
// - reload bit with boot pin low reloads
// - unlock bit defaults zero, blocks saves
// - save bit starts buffer-to-store copy
// - save bit self-clears when save ends
// - bit7 zero: count-1, then address MSB first
// - commit opcode copies buffer to active
// - end opcode terminates the transfer
module nv_config_save_load_control #(
   parameter int FIFO_DEPTH = 8,
   parameter int IDLE_CYCLES = nv_cfg_pkg::IDLE_GAP_CYC
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [11:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   input wire logic bootSelPin,
   output logic statusPin,
   output logic [11:0] bufAddr,
   input wire logic [7:0] bufRdData,
   output logic bufWrEn,
   output logic [7:0] bufWrData,
   output logic commitPulse,
   output logic softResetPulse,
   output logic nvValid,
   input wire logic nvReady,
   output logic nvWrite,
   output logic [11:0] nvAddr,
   output logic [7:0] nvWrData,
   input wire logic nvRdValid,
   input wire logic [7:0] nvRdData,
   input wire logic nvRdBad
);
   typedef struct packed {
      nv_cfg_pkg::eng_state_t state;
      logic pending;
      logic error;
      logic unlock;
      logic reload;
      logic save;
      logic statusSel;
      logic isSave;
      logic [7:0] scriptPtr;
      logic [6:0] remain;
      logic [11:0] moveAddr;
      logic [7:0] rdData;
      logic commit;
      logic softRst;
      logic bufWe;
      logic [7:0] bufWd;
      logic [11:0] bufWa;
      logic [1:0] bootSync;
   } ctl_t;
   ctl_t st_q, st_d;

   logic fifoInReady;
   logic fifoOutValid;
   logic [19:0] fifoOutData;
   logic fifoPush;
   logic fifoFlush;
   logic moving;

   // ------------------------------------------------------------
   // save data fifo towards the store
   // ------------------------------------------------------------
   nv_data_fifo #(.WIDTH(20), .DEPTH(FIFO_DEPTH)) dataFifo (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .clkEn(clkEn),
      .flush(fifoFlush),
      .inData({st_q.moveAddr, bufRdData}),
      .inValid(fifoPush),
      .inReady(fifoInReady),
      .outData(fifoOutData),
      .outValid(fifoOutValid),
      .outReady(nvReady)
   );

   assign moving = (st_q.state == nv_cfg_pkg::S_MOVE);
   assign fifoPush = moving && st_q.isSave;
   assign fifoFlush = (st_q.state == nv_cfg_pkg::S_IDLE);
   assign nvValid = fifoOutValid;
   assign nvWrite = fifoOutValid;
   assign nvAddr = fifoOutData[19:8];
   assign nvWrData = fifoOutData[7:0];
   assign statusPin = st_q.statusSel && st_q.pending;
   assign bufAddr = moving ? st_q.moveAddr :
                    (nv_cfg_pkg::ADDR_SCRIPT_BASE | {4'h0, st_q.scriptPtr});
   assign bufWrEn = st_q.bufWe;
   assign bufWrData = st_q.bufWd;
   assign commitPulse = st_q.commit;
   assign softResetPulse = st_q.softRst;
   assign regRdData = st_q.rdData;

   // ------------------------------------------------------------
   // registers and transfer engine
   // ------------------------------------------------------------
   always_comb begin
      logic startSave;
      logic startLoad;
      logic stepDone;
      logic [7:0] cmd;
      startSave = 1'b0;
      startLoad = 1'b0;
      stepDone = 1'b0;
      cmd = bufRdData;
      st_d = st_q;
      st_d.commit = 1'b0;
      st_d.softRst = 1'b0;
      st_d.bufWe = 1'b0;
      st_d.bootSync = {st_q.bootSync[0], bootSelPin};
      if (regRdEn) begin
         unique case (regAddr)
            nv_cfg_pkg::ADDR_PENDING: st_d.rdData = 8'(st_q.pending);
            nv_cfg_pkg::ADDR_ERROR: st_d.rdData = 8'(st_q.error);
            nv_cfg_pkg::ADDR_RELOAD: st_d.rdData = {6'h00, st_q.reload, st_q.unlock};
            nv_cfg_pkg::ADDR_SAVE: st_d.rdData = 8'(st_q.save);
            nv_cfg_pkg::ADDR_STATUS_SEL: st_d.rdData = {st_q.statusSel, 7'h00};
            default: st_d.rdData = 8'h00;
         endcase
      end
      if (regWrEn) begin
         unique case (regAddr)
            nv_cfg_pkg::ADDR_RELOAD: begin
               st_d.unlock = regWrData[nv_cfg_pkg::BIT_UNLOCK];
               if (regWrData[nv_cfg_pkg::BIT_RELOAD] && !st_q.bootSync[1]
                   && !st_q.pending) begin
                  st_d.reload = 1'b1;
                  startLoad = 1'b1;
               end
            end
            nv_cfg_pkg::ADDR_SAVE: begin
               if (regWrData[nv_cfg_pkg::BIT_SAVE] && st_q.unlock && !st_q.pending) begin
                  st_d.save = 1'b1;
                  startSave = 1'b1;
               end
            end
            nv_cfg_pkg::ADDR_STATUS_SEL: st_d.statusSel = regWrData[nv_cfg_pkg::BIT_STATUS_SEL];
            nv_cfg_pkg::ADDR_UPDATE: st_d.commit = regWrData[nv_cfg_pkg::BIT_UPDATE];
            default: ;
         endcase
      end
      if (startSave || startLoad) begin
         st_d.state = nv_cfg_pkg::S_CMD;
         st_d.pending = 1'b1;
         st_d.error = 1'b0;
         st_d.isSave = startSave;
         st_d.scriptPtr = 8'h00;
         st_d.softRst = startLoad;
      end
      unique case (st_q.state)
         nv_cfg_pkg::S_IDLE: ;
         nv_cfg_pkg::S_CMD: begin
            st_d.scriptPtr = st_q.scriptPtr + 8'h01;
            if (!cmd[nv_cfg_pkg::BIT_OPCODE]) begin
               st_d.remain = cmd[6:0];
               st_d.state = nv_cfg_pkg::S_ADDR_HI;
            end else if (cmd == nv_cfg_pkg::OP_COMMIT) begin
               st_d.commit = 1'b1;
            end else begin
               st_d.state = nv_cfg_pkg::S_DONE;
            end
            if (st_q.scriptPtr == nv_cfg_pkg::SCRIPT_LAST) begin
               st_d.state = nv_cfg_pkg::S_DONE;
            end
         end
         nv_cfg_pkg::S_ADDR_HI: begin
            st_d.moveAddr[11:8] = cmd[3:0];
            st_d.scriptPtr = st_q.scriptPtr + 8'h01;
            st_d.state = nv_cfg_pkg::S_ADDR_LO;
         end
         nv_cfg_pkg::S_ADDR_LO: begin
            st_d.moveAddr[7:0] = cmd;
            st_d.scriptPtr = st_q.scriptPtr + 8'h01;
            st_d.state = nv_cfg_pkg::S_MOVE;
         end
         nv_cfg_pkg::S_MOVE: begin
            if (st_q.isSave) begin
               stepDone = fifoInReady;
            end else if (nvRdValid) begin
               stepDone = 1'b1;
               st_d.bufWe = 1'b1;
               st_d.bufWd = nvRdData;
               st_d.bufWa = st_q.moveAddr;
               st_d.error = st_q.error || nvRdBad;
            end
            if (stepDone) begin
               st_d.moveAddr = st_q.moveAddr + 12'h001;
               st_d.remain = st_q.remain - 7'h01;
               if (st_q.remain == 7'h00) begin
                  st_d.state = nv_cfg_pkg::S_CMD;
               end
            end
         end
         nv_cfg_pkg::S_DONE: begin
            if (!fifoOutValid) begin
               st_d.state = nv_cfg_pkg::S_IDLE;
               st_d.pending = 1'b0;
               st_d.save = 1'b0;
               st_d.reload = 1'b0;
            end
         end
         default: st_d.state = nv_cfg_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= '0;
      end else if (clkEn) begin
         st_q <= st_d;
      end
   end
endmodule : nv_config_save_load_control

`default_nettype wire

// *** dv/nv_cfg_asserts.sv ***
/* port checker for the save/load control block.
 assumes a bind onto nv_config_save_load_control. */
`timescale 1ns/10ps
`default_nettype none
module nv_cfg_asserts (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic regRdEn,
   input wire logic regWrEn,
   input wire logic [11:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic statusPin,
   input wire logic bufWrEn,
   input wire logic [7:0] bufWrData,
   input wire logic commitPulse,
   input wire logic softResetPulse,
   input wire logic nvValid,
   input wire logic nvReady,
   input wire logic [11:0] nvAddr,
   input wire logic [7:0] nvWrData,
   input wire logic nvRdValid,
   input wire logic [7:0] nvRdData
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   sequence sRd(a);
      clkEn && regRdEn && regAddr == a;
   endsequence
   sequence sWait;
      nvValid && !nvReady;
   endsequence
   pend_read_a: assert property (sRd(nv_cfg_pkg::ADDR_PENDING) |=> regRdData[7:1] == 7'h00)
      else $error("pending read upper bits set");
   status_read_a: assert property (sRd(nv_cfg_pkg::ADDR_PENDING) ##0 statusPin |=> regRdData[0])
      else $error("status pin high but pending reads 0");
   err_read_a: assert property (sRd(nv_cfg_pkg::ADDR_ERROR) |=> regRdData[7:1] == 7'h00)
      else $error("error read upper bits set");
   commit_write_a: assert property (clkEn && regWrEn && regAddr == nv_cfg_pkg::ADDR_UPDATE
      && regWrData[0] |=> commitPulse)
      else $error("commit write gave no pulse");
   reset_pulse_a: assert property (softResetPulse |=> !softResetPulse)
      else $error("soft reset pulse too long");
   save_hold_a: assert property (sWait |=> nvValid && $stable(nvAddr) && $stable(nvWrData))
      else $error("save byte dropped before accept");
   load_write_a: assert property (bufWrEn |-> $past(nvRdValid) && bufWrData == $past(nvRdData))
      else $error("buffer write without loaded byte");
   read_hold_a: assert property (!(clkEn && regRdEn) |=> $stable(regRdData))
      else $error("read data changed without read");
endmodule : nv_cfg_asserts
bind nv_config_save_load_control nv_cfg_asserts u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
   .clkEn(clkEn), .regRdEn(regRdEn), .regWrEn(regWrEn), .regAddr(regAddr),
   .regWrData(regWrData), .regRdData(regRdData), .statusPin(statusPin), .bufWrEn(bufWrEn),
   .bufWrData(bufWrData), .commitPulse(commitPulse), .softResetPulse(softResetPulse),
   .nvValid(nvValid), .nvReady(nvReady), .nvAddr(nvAddr), .nvWrData(nvWrData),
   .nvRdValid(nvRdValid), .nvRdData(nvRdData));
`default_nettype wire

// *** dv/nv_store_model.sv ***
/* nonvolatile store model: slow accept of saved bytes, two loaded bytes.
 assumes serve is raised by the bench for a load. */
`timescale 1ns/10ps
`default_nettype none
module nv_store_model (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic nvValid,
   output logic nvReady,
   input wire logic [11:0] nvAddr,
   input wire logic [7:0] nvWrData,
   output logic nvRdValid,
   output logic [7:0] nvRdData,
   output logic nvRdBad,
   input wire logic serve
);
   int saveCnt;
   int loadCnt;
   logic [11:0] lastAddr;
   logic [7:0] lastData;
   logic [1:0] tick;
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         saveCnt <= 0;
         loadCnt <= 0;
         tick <= 2'h0;
         nvReady <= 1'b0;
         nvRdValid <= 1'b0;
         nvRdBad <= 1'b0;
         nvRdData <= 8'h00;
      end else begin
         if (!serve) begin
            tick <= 2'h0;
         end else begin
            tick <= tick + 2'h1;
         end
         nvReady <= ~nvReady;
         if (nvValid && nvReady) begin
            saveCnt <= saveCnt + 1;
            lastAddr <= nvAddr;
            lastData <= nvWrData;
         end
         if (serve && tick == 2'h3 && loadCnt < 2) begin
            nvRdValid <= 1'b1;
            nvRdData <= 8'hC0 + 8'(loadCnt);
            nvRdBad <= loadCnt == 1;
            loadCnt <= loadCnt + 1;
         end else begin
            nvRdValid <= 1'b0;
            nvRdData <= ~nvRdData;
            nvRdBad <= 1'b0;
         end
      end
   end
endmodule : nv_store_model
`default_nettype wire

// *** dv/tb.sv ***
/* register-level bench for the save/load control block.
 assumes the store model and a script held in the buffer bank. */
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk_sys = 1'b0, arst_n = 1'b0, clkEn = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
   logic bootSelPin = 1'b0, serve = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] regRdData, bufRdData, bufWrData, nvWrData, nvRdData, v;
   logic [11:0] bufAddr, nvAddr;
   logic statusPin, bufWrEn, commitPulse, softResetPulse, nvValid, nvReady, nvWrite;
   logic nvRdValid, nvRdBad;
   logic [7:0] lastBufWr = 8'h00;
   int errors = 0, check_count = 0, nCommit = 0, nSoft = 0, nBufWr = 0;
   always #2.5 clk_sys = ~clk_sys;
   always_comb begin
      case (bufAddr)
         12'hA00: bufRdData = 8'h01;
         12'hA01: bufRdData = 8'h00;
         12'hA02: bufRdData = 8'h10;
         12'hA03: bufRdData = nv_cfg_pkg::OP_COMMIT;
         default: bufRdData = bufAddr[11:8] == 4'hA ? nv_cfg_pkg::OP_END : bufAddr[7:0] ^ 8'h5A;
      endcase
   end
   nv_config_save_load_control dut (.clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
      .regRdData(regRdData), .bootSelPin(bootSelPin), .statusPin(statusPin), .bufAddr(bufAddr),
      .bufRdData(bufRdData), .bufWrEn(bufWrEn), .bufWrData(bufWrData), .commitPulse(commitPulse),
      .softResetPulse(softResetPulse), .nvValid(nvValid), .nvReady(nvReady), .nvWrite(nvWrite),
      .nvAddr(nvAddr), .nvWrData(nvWrData), .nvRdValid(nvRdValid), .nvRdData(nvRdData),
      .nvRdBad(nvRdBad));
   nv_store_model nvm (.clk_sys(clk_sys), .arst_n(arst_n), .nvValid(nvValid), .nvReady(nvReady),
      .nvAddr(nvAddr), .nvWrData(nvWrData), .nvRdValid(nvRdValid), .nvRdData(nvRdData),
      .nvRdBad(nvRdBad), .serve(serve));
   always @(posedge clk_sys) begin
      nCommit += commitPulse;
      nSoft += softResetPulse;
      nBufWr += bufWrEn;
      if (bufWrEn) lastBufWr <= bufWrData;
   end
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk_sys);
      regWrEn = 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk_sys);
      regRdEn = 1'b0;
      d = regRdData;
   endtask : rd
   task automatic settle();
      rd(nv_cfg_pkg::ADDR_PENDING, v);
      for (int i = 0; i < 400 && v[0] !== 1'b0; i++) rd(nv_cfg_pkg::ADDR_PENDING, v);
      chk("pending end", 0, v);
      repeat (nv_cfg_pkg::IDLE_GAP_CYC) @(negedge clk_sys);
   endtask : settle
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(negedge clk_sys);
      arst_n = 1'b1;
      rd(nv_cfg_pkg::ADDR_PENDING, v); chk("pending", 0, v);
      rd(nv_cfg_pkg::ADDR_ERROR, v); chk("error", 0, v);
      rd(nv_cfg_pkg::ADDR_RELOAD, v); chk("unlock", 0, v);
      wr(nv_cfg_pkg::ADDR_SAVE, 8'h01);
      rd(nv_cfg_pkg::ADDR_SAVE, v); chk("locked save", 0, v);
      rd(12'h123, v); chk("unmapped", 0, v);
      wr(nv_cfg_pkg::ADDR_STATUS_SEL, 8'h80);
      wr(nv_cfg_pkg::ADDR_RELOAD, 8'h01);
      wr(nv_cfg_pkg::ADDR_SAVE, 8'h01);
      rd(nv_cfg_pkg::ADDR_SAVE, v); chk("save busy", 1, v);
      chk("status pin", 1, statusPin);
      settle();
      rd(nv_cfg_pkg::ADDR_SAVE, v); chk("save clear", 0, v);
      chk("saved bytes", 2, nvm.saveCnt);
      chk("last addr", 12'h011, nvm.lastAddr);
      chk("last data", 8'h4B, nvm.lastData);
      chk("script commit", 1, nCommit);
      wr(nv_cfg_pkg::ADDR_UPDATE, 8'h01);
      @(negedge clk_sys); chk("reg commit", 2, nCommit);
      wr(nv_cfg_pkg::ADDR_RELOAD, 8'h03);
      @(negedge clk_sys); chk("soft reset", 1, nSoft);
      serve = 1'b1;
      settle();
      serve = 1'b0;
      rd(nv_cfg_pkg::ADDR_ERROR, v); chk("load error", 1, v);
      chk("loaded bytes", 2, nBufWr);
      chk("loaded data", 8'hC1, lastBufWr);
      rd(nv_cfg_pkg::ADDR_RELOAD, v); chk("reload clear", 1, v);
      bootSelPin = 1'b1;
      repeat (4) @(negedge clk_sys);
      wr(nv_cfg_pkg::ADDR_RELOAD, 8'h03);
      rd(nv_cfg_pkg::ADDR_PENDING, v); chk("boot high", 0, v);
      chk("no reset", 1, nSoft);
      clkEn = 1'b0;
      wr(nv_cfg_pkg::ADDR_SAVE, 8'h01);
      clkEn = 1'b1;
      rd(nv_cfg_pkg::ADDR_PENDING, v); chk("frozen", 0, v);
      wr(nv_cfg_pkg::ADDR_SAVE, 8'h01);
      rd(nv_cfg_pkg::ADDR_ERROR, v); chk("error cleared", 0, v);
      settle();
      print_verdict();
   end
   initial begin
      repeat (30000) @(posedge clk_sys);
      errors++;
      print_verdict();
   end
endmodule : tb
`default_nettype wire
